// ---- rtl/rpe_consts.svh ----
// Constants for the RAM protection and lock-step block
`ifndef RPE_CONSTS_SVH
`define RPE_CONSTS_SVH

`define RPE_DATA_W 32
`define RPE_BYTES 4
`define RPE_ECC_W 7
`define RPE_WIDE_ECC_W 8
`define RPE_ADDR_W 10
`define RPE_DEPTH 1024
`define RPE_OUT_W 32
`define RPE_LOCK_DELAY 2

`endif

// ---- rtl/rpe_pkg.sv ----
// Types for the RAM protection and lock-step block
package rpe_pkg;
    typedef enum logic [2:0] {
        RPE_IDLE,
        RPE_RD,
        RPE_CHECK,
        RPE_FIX,
        RPE_RMW_WR,
        RPE_ABORT
    } rpe_state_t;

    typedef enum logic [1:0] {
        RPE_PROT_NONE,
        RPE_PROT_PARITY,
        RPE_PROT_ECC
    } rpe_prot_t;
endpackage : rpe_pkg

// ---- rtl/rpe_ram_if.sv ----
// Carrier between the protection controller and its RAM
`include "rpe_consts.svh"
interface rpe_ram_if;
    logic en;
    logic we;
    logic [`RPE_ADDR_W-1:0] addr;
    logic [`RPE_DATA_W+`RPE_ECC_W-1:0] wdata;
    logic [`RPE_DATA_W+`RPE_ECC_W-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface : rpe_ram_if

// ---- rtl/rpe_ram.sv ----
// Protected word store with registered read data
`include "rpe_consts.svh"
module rpe_ram (
    // Clock
    input wire logic clk_sys_i,
    // Port
    rpe_ram_if.mem ram
);
    logic [`RPE_DATA_W+`RPE_ECC_W-1:0] mem_q [`RPE_DEPTH];
    logic [`RPE_DATA_W+`RPE_ECC_W-1:0] rdata_q;

    always_ff @(posedge clk_sys_i) begin
        if (ram.en && ram.we) begin
            mem_q[ram.addr] <= ram.wdata;
        end
        if (ram.en) begin
            rdata_q <= mem_q[ram.addr];
        end
    end

    assign ram.rdata = rdata_q;
endmodule : rpe_ram

// ---- rtl/rpe_ctrl.sv ----
// RAM parity/SEC-DED controller with lock-step comparator
`include "rpe_consts.svh"
module rpe_ctrl #(
    parameter int LOCK_DELAY = `RPE_LOCK_DELAY
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Configuration
    input wire rpe_pkg::rpe_prot_t prot_mode_i,
    input wire logic odd_parity_i,
    input wire logic is_cache_i,
    input wire logic line_dirty_i,
    input wire logic is_fetch_i,
    // Requester
    input wire logic req_i,
    input wire logic req_we_i,
    input wire logic [`RPE_ADDR_W-1:0] req_addr_i,
    input wire logic [`RPE_DATA_W-1:0] req_wdata_i,
    input wire logic [`RPE_BYTES-1:0] req_be_i,
    output logic req_ready_o,
    output logic rsp_valid_o,
    output logic [`RPE_DATA_W-1:0] rsp_rdata_o,
    // Abort and recovery
    output logic fetch_abort_o,
    output logic data_abort_o,
    output logic line_inval_o,
    output logic [`RPE_ADDR_W-1:0] line_inval_addr_o,
    // Events and status record
    output logic ev_corr_o,
    output logic ev_uncorr_o,
    output logic ev_lock_o,
    output logic ev_fatal_o,
    output logic [`RPE_ADDR_W-1:0] fault_addr_o,
    output logic [2:0] fault_status_o,
    // Lock-step pair
    input wire logic [`RPE_OUT_W-1:0] primary_out_i,
    input wire logic [`RPE_OUT_W-1:0] redundant_out_i,
    input wire logic [`RPE_OUT_W-1:0] lock_in_i,
    output logic [`RPE_OUT_W-1:0] redundant_in_o
);
    localparam int DW = `RPE_DATA_W;
    localparam int CW = `RPE_ECC_W;
    localparam int WCW = `RPE_WIDE_ECC_W;

    // ------------------------------------------------------------
    // Code functions
    // ------------------------------------------------------------
    // Hamming positions 1..38, overall parity in bit 0 of the check field.
    // per-byte parity, even unless odd is set
    function automatic logic [3:0] par_gen(input logic [DW-1:0] d, input logic odd);
        logic [3:0] p;
        p = '0;
        for (int b = 0; b < `RPE_BYTES; b++) begin
            p[b] = (^d[b*8 +: 8]) ^ odd;
        end
        return p;
    endfunction : par_gen
    // seven check bits
    // Same layout as the wide code; a zero upper half adds nothing to any check bit
    function automatic logic [CW-1:0] ecc_gen(input logic [DW-1:0] d);
        logic [WCW-1:0] w;
        w = ecc_gen_wide({{DW{1'b0}}, d});
        return w[CW-1:0];
    endfunction : ecc_gen
    // eight bits for a wide chunk
    function automatic logic [WCW-1:0] ecc_gen_wide(input logic [2*DW-1:0] d);
        logic [WCW-1:0] c;
        logic [6:0] pos;
        int k;
        c = '0;
        k = 0;
        for (int p = 3; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                pos = 7'(p);
                for (int i = 0; i < 7; i++) begin
                    if (pos[i]) begin
                        c[i+1] = c[i+1] ^ d[k];
                    end
                end
                k++;
            end
        end
        c[0] = (^d) ^ (^c[WCW-1:1]);
        return c;
    endfunction : ecc_gen_wide
    // Data bit index at Hamming position, or 6'h3F for a check position
    function automatic logic [5:0] pos_to_bit(input logic [5:0] pos);
        int k;
        logic [5:0] r;
        r = 6'h3F;
        k = 0;
        for (int p = 3; p < 39; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (6'(p) == pos) begin
                    r = 6'(k);
                end
                k++;
            end
        end
        return r;
    endfunction : pos_to_bit
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                            input logic [`RPE_BYTES-1:0] be);
        logic [DW-1:0] m;
        m = old;
        for (int b = 0; b < `RPE_BYTES; b++) begin
            if (be[b]) begin
                m[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge
    function automatic logic [DW+CW-1:0] encode(input logic [DW-1:0] d, input rpe_pkg::rpe_prot_t m,
                                              input logic odd);
        return (m == rpe_pkg::RPE_PROT_ECC) ? {d, ecc_gen(d)} : {d, 3'h0, par_gen(d, odd)};
    endfunction : encode
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rpe_pkg::rpe_state_t st;
        logic we;
        logic [`RPE_ADDR_W-1:0] addr;
        logic [DW-1:0] wdata;
        logic [`RPE_BYTES-1:0] be;
        logic fetch;
        logic rsp_valid;
        logic [DW-1:0] rdata;
        logic fetch_abort;
        logic data_abort;
        logic inval;
        logic ev_corr;
        logic ev_uncorr;
        logic ev_lock;
        logic ev_fatal;
        logic [`RPE_ADDR_W-1:0] fault_addr;
        logic [2:0] fault_status;
        logic [LOCK_DELAY*`RPE_OUT_W-1:0] in_pipe;
        logic [LOCK_DELAY*`RPE_OUT_W-1:0] pri_pipe;
        logic [LOCK_DELAY-1:0] lock_fill;
    } rpe_ctrl_state_t;
    rpe_ctrl_state_t s_q;
    rpe_ctrl_state_t s_d;
    rpe_ram_if ram ();
    rpe_ram u_ram (
        .clk_sys_i(clk_sys_i),
        .ram(ram)
    );

    // ------------------------------------------------------------
    // Checker
    // ------------------------------------------------------------
    logic [DW-1:0] rd_data;
    logic [CW-1:0] rd_chk;
    logic [CW-1:0] syn;
    logic par_err;
    logic single_err;
    logic double_err;
    logic [5:0] flip_bit;
    logic [DW-1:0] fixed_data;
    always_comb begin
        rd_data = ram.rdata[DW+CW-1:CW];
        rd_chk = ram.rdata[CW-1:0];
        par_err = |(par_gen(rd_data, s_q.fetch ? odd_parity_i : odd_parity_i) ^ rd_chk[3:0]);
        // syndrome over data and check bits
        syn = ecc_gen(rd_data) ^ rd_chk;
        single_err = syn[0];
        double_err = !syn[0] && (syn[CW-1:1] != '0);
        flip_bit = pos_to_bit(6'(syn[CW-1:1]));
        fixed_data = rd_data;
        if (prot_mode_i == rpe_pkg::RPE_PROT_ECC && single_err && flip_bit != 6'h3F) begin
            fixed_data[flip_bit[4:0]] = ~rd_data[flip_bit[4:0]];
        end
    end

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    logic [DW-1:0] merged;
    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.fetch_abort = 1'b0;
        s_d.data_abort = 1'b0;
        s_d.inval = 1'b0;
        s_d.ev_corr = 1'b0;
        s_d.ev_uncorr = 1'b0;
        s_d.ev_lock = 1'b0;
        s_d.ev_fatal = 1'b0;
        ram.en = 1'b0;
        ram.we = 1'b0;
        ram.addr = s_q.addr;
        ram.wdata = '0;
        merged = merge(fixed_data, s_q.wdata, s_q.be);
        unique case (s_q.st)
            rpe_pkg::RPE_IDLE: begin
                if (req_i) begin
                    s_d.we = req_we_i;
                    s_d.addr = req_addr_i;
                    s_d.wdata = req_wdata_i;
                    s_d.be = req_be_i;
                    s_d.fetch = is_fetch_i;
                    ram.addr = req_addr_i;
                    ram.en = 1'b1;
                    if (req_we_i && (req_be_i == '1 || prot_mode_i == rpe_pkg::RPE_PROT_NONE)) begin
                        ram.we = 1'b1;
                        ram.wdata = encode(req_wdata_i, prot_mode_i, odd_parity_i);
                        s_d.rsp_valid = 1'b1;
                    end else begin
                        s_d.st = rpe_pkg::RPE_RD;
                    end
                end
            end
            rpe_pkg::RPE_RD: begin
                s_d.st = rpe_pkg::RPE_CHECK;
            end
            rpe_pkg::RPE_CHECK: begin
                if (prot_mode_i == rpe_pkg::RPE_PROT_PARITY && par_err) begin
                    s_d.st = rpe_pkg::RPE_ABORT;
                end else if (prot_mode_i == rpe_pkg::RPE_PROT_ECC && double_err) begin
                    s_d.st = rpe_pkg::RPE_ABORT;
                end else if (prot_mode_i == rpe_pkg::RPE_PROT_ECC && single_err) begin
                    s_d.st = rpe_pkg::RPE_FIX;
                    s_d.ev_corr = 1'b1;
                    s_d.fault_addr = s_q.addr;
                    s_d.fault_status = 3'h1;
                end else if (s_q.we) begin
                    s_d.st = rpe_pkg::RPE_RMW_WR;
                end else begin
                    s_d.rsp_valid = 1'b1;
                    s_d.rdata = rd_data;
                    s_d.st = rpe_pkg::RPE_IDLE;
                end
                if (s_d.st == rpe_pkg::RPE_ABORT) begin
                    s_d.fetch_abort = s_q.fetch;
                    s_d.data_abort = !s_q.fetch;
                    s_d.ev_uncorr = 1'b1;
                    s_d.fault_addr = s_q.addr;
                    s_d.fault_status = (prot_mode_i == rpe_pkg::RPE_PROT_PARITY) ? 3'h2 : 3'h3;
                    if (is_cache_i && !line_dirty_i) begin
                        s_d.inval = 1'b1;
                    end else begin
                        s_d.ev_fatal = 1'b1;
                        s_d.fault_status = 3'h4;
                    end
                end
            end
            rpe_pkg::RPE_FIX: begin
                ram.en = 1'b1;
                ram.we = 1'b1;
                ram.wdata = encode(s_q.we ? merged : fixed_data, prot_mode_i, odd_parity_i);
                s_d.rsp_valid = 1'b1;
                s_d.rdata = fixed_data;
                s_d.st = rpe_pkg::RPE_IDLE;
            end
            rpe_pkg::RPE_RMW_WR: begin
                ram.en = 1'b1;
                ram.we = 1'b1;
                ram.wdata = encode(merged, prot_mode_i, odd_parity_i);
                s_d.rsp_valid = 1'b1;
                s_d.st = rpe_pkg::RPE_IDLE;
            end
            rpe_pkg::RPE_ABORT: begin
                s_d.st = rpe_pkg::RPE_IDLE;
            end
        endcase
        s_d.in_pipe = {s_q.in_pipe[(LOCK_DELAY-1)*`RPE_OUT_W-1:0], lock_in_i};
        s_d.pri_pipe = {s_q.pri_pipe[(LOCK_DELAY-1)*`RPE_OUT_W-1:0], primary_out_i};
        // Compare only once the delay lines hold real samples, so reset raises no false fault
        s_d.lock_fill = {s_q.lock_fill[LOCK_DELAY-2:0], 1'b1};
        if (s_q.lock_fill[LOCK_DELAY-1] && s_q.pri_pipe[LOCK_DELAY*`RPE_OUT_W-1 -: `RPE_OUT_W] != redundant_out_i) begin
            s_d.ev_lock = 1'b1;
            s_d.fault_status = 3'h5;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign req_ready_o = (s_q.st == rpe_pkg::RPE_IDLE);
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_rdata_o = s_q.rdata;
    assign fetch_abort_o = s_q.fetch_abort;
    assign data_abort_o = s_q.data_abort;
    assign line_inval_o = s_q.inval;
    assign line_inval_addr_o = s_q.fault_addr;
    assign ev_corr_o = s_q.ev_corr;
    assign ev_uncorr_o = s_q.ev_uncorr;
    assign ev_lock_o = s_q.ev_lock;
    assign ev_fatal_o = s_q.ev_fatal;
    assign fault_addr_o = s_q.fault_addr;
    assign fault_status_o = s_q.fault_status;
    assign redundant_in_o = s_q.in_pipe[LOCK_DELAY*`RPE_OUT_W-1 -: `RPE_OUT_W];
endmodule : rpe_ctrl

// ---- test/rpe_ctrl_properties.sv ----
// Port-level properties of the RAM protection controller
`include "rpe_consts.svh"
module rpe_ctrl_properties #(
    parameter int LOCK_DELAY = 2
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Configuration and request
    input wire rpe_pkg::rpe_prot_t prot_mode_i,
    input wire logic is_fetch_i,
    input wire logic req_i,
    input wire logic req_we_i,
    input wire logic [`RPE_ADDR_W-1:0] req_addr_i,
    input wire logic [`RPE_BYTES-1:0] req_be_i,
    input wire logic req_ready_o,
    input wire logic rsp_valid_o,
    // Aborts, events, status
    input wire logic fetch_abort_o,
    input wire logic data_abort_o,
    input wire logic line_inval_o,
    input wire logic [`RPE_ADDR_W-1:0] line_inval_addr_o,
    input wire logic ev_corr_o,
    input wire logic ev_uncorr_o,
    input wire logic ev_lock_o,
    input wire logic [`RPE_ADDR_W-1:0] fault_addr_o,
    input wire logic [2:0] fault_status_o,
    // Lock-step pair
    input wire logic [`RPE_OUT_W-1:0] primary_out_i,
    input wire logic [`RPE_OUT_W-1:0] redundant_out_i,
    input wire logic [`RPE_OUT_W-1:0] lock_in_i,
    input wire logic [`RPE_OUT_W-1:0] redundant_in_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cnt_q;
    logic fetch_q;
    logic [`RPE_ADDR_W-1:0] addr_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // --------------------------------
    // Helper state
    // --------------------------------
    // Cycle count keeps $past away from the reset values of the delay line
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cnt_q <= 3'h0;
            fetch_q <= 1'h0;
            addr_q <= '0;
        end else begin
            if (cnt_q != 3'h7) begin
                cnt_q <= cnt_q + 3'h1;
            end
            if (req_i && req_ready_o) begin
                fetch_q <= is_fetch_i;
                addr_q <= req_addr_i;
            end
        end
    end

    // --------------------------------
    // Properties
    // --------------------------------
    chk_req_stall: assert property (req_i && req_ready_o && !(req_we_i && (req_be_i == 4'hF ||
        prot_mode_i == rpe_pkg::RPE_PROT_NONE)) |=> !req_ready_o)
        else $error("ready stays high after a taken request");
    chk_full_write: assert property (req_i && req_ready_o && req_we_i && req_be_i == 4'hF |=> rsp_valid_o)
        else $error("full write not answered next cycle");
    chk_rmw_read: assert property (req_i && req_ready_o && req_we_i && req_be_i != 4'hF &&
        prot_mode_i != rpe_pkg::RPE_PROT_NONE |-> ##1 !rsp_valid_o [*3])
        else $error("partial write answered before its read");
    chk_read_wait: assert property (req_i && req_ready_o && !req_we_i |-> ##1 !rsp_valid_o [*2])
        else $error("read answered before check");
    chk_abort_kind: assert property (fetch_abort_o || data_abort_o |->
        fetch_abort_o == fetch_q && data_abort_o != fetch_q && !rsp_valid_o)
        else $error("abort kind does not match access");
    chk_fault_addr: assert property (fetch_abort_o || data_abort_o || line_inval_o |->
        fault_addr_o == addr_q && line_inval_addr_o == addr_q)
        else $error("failing address not recorded");
    chk_corr_status: assert property (ev_corr_o |-> fault_status_o == 3'h1 && !fetch_abort_o && !data_abort_o)
        else $error("corrected event with wrong status");
    chk_event_pulse: assert property (ev_corr_o || ev_uncorr_o |=> !ev_corr_o && !ev_uncorr_o)
        else $error("error event longer than one cycle");
    chk_lock_flag: assert property (cnt_q == 3'h7 && $past(primary_out_i, LOCK_DELAY) != redundant_out_i
        |=> ev_lock_o && fault_status_o == 3'h5)
        else $error("lock-step difference not flagged");
    chk_lock_quiet: assert property (cnt_q == 3'h7 && $past(primary_out_i, LOCK_DELAY) == redundant_out_i
        |=> !ev_lock_o)
        else $error("lock-step flag without difference");
    chk_red_delay: assert property (cnt_q == 3'h7 |-> redundant_in_o == $past(lock_in_i, LOCK_DELAY))
        else $error("redundant inputs not delayed");
endmodule : rpe_ctrl_properties

// ---- test/rpe_lock_pair.sv ----
// Model of the primary and redundant logic copies
`include "rpe_consts.svh"
module rpe_lock_pair (
    // Inputs
    input wire logic [`RPE_OUT_W-1:0] lock_in_i,
    input wire logic [`RPE_OUT_W-1:0] redundant_in_i,
    input wire logic inject_i,
    // Outputs
    output logic [`RPE_OUT_W-1:0] primary_out_o,
    output logic [`RPE_OUT_W-1:0] redundant_out_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Same work in both copies; only the input timing and the inject flip differ
    function automatic logic [`RPE_OUT_W-1:0] work(input logic [`RPE_OUT_W-1:0] x);
        return {x[15:0], x[31:16]} ^ 32'h5A5A0F0F;
    endfunction : work

    assign primary_out_o = work(lock_in_i);
    // Inject flips one bit to stand for an upset in the redundant copy
    assign redundant_out_o = work(redundant_in_i) ^ {31'h0, inject_i};
endmodule : rpe_lock_pair

// ---- test/tb_top.sv ----
// Self-checking bench for the RAM protection controller
`include "rpe_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    rpe_pkg::rpe_prot_t mode = rpe_pkg::RPE_PROT_NONE;
    logic odd = 1'h0, cache = 1'h0, dirty = 1'h0, fetch = 1'h0, req = 1'h0, we = 1'h0, inject = 1'h0;
    logic [3:0] be = 4'hF;
    logic [9:0] addr = 10'h0, a, linv_a, f_addr;
    logic [31:0] wdata = 32'h0, lin = 32'h0, d, w, rdata, rd_s, prim, red, red_in;
    logic ready, rsp_v, fab, dab, linv, ev_c, ev_u, ev_l, ev_f;
    logic [2:0] f_st, ab_s, ev_s;
    int seed = 79828;
    int error_cnt = 0;
    int num_checks = 0;

    always #12.5 clk_sys_i = ~clk_sys_i;

    rpe_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .prot_mode_i(mode), .odd_parity_i(odd),
        .is_cache_i(cache), .line_dirty_i(dirty), .is_fetch_i(fetch), .req_i(req), .req_we_i(we),
        .req_addr_i(addr), .req_wdata_i(wdata), .req_be_i(be), .req_ready_o(ready), .rsp_valid_o(rsp_v),
        .rsp_rdata_o(rdata), .fetch_abort_o(fab), .data_abort_o(dab), .line_inval_o(linv),
        .line_inval_addr_o(linv_a), .ev_corr_o(ev_c), .ev_uncorr_o(ev_u), .ev_lock_o(ev_l), .ev_fatal_o(ev_f),
        .fault_addr_o(f_addr), .fault_status_o(f_st), .primary_out_i(prim), .redundant_out_i(red),
        .lock_in_i(lin), .redundant_in_o(red_in));

    rpe_lock_pair u_pair (.lock_in_i(lin), .redundant_in_i(red_in), .inject_i(inject),
        .primary_out_o(prim), .redundant_out_o(red));

    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // One request; idle cycle first so the previous answer has cleared
    task automatic xfer(input logic wr, input logic [9:0] ad, input logic [31:0] dt, input logic [3:0] b, input int lat);
        int n;
        @(posedge clk_sys_i);
        #2;
        req = 1'h1;
        we = wr;
        addr = ad;
        wdata = dt;
        be = b;
        @(posedge clk_sys_i);
        #2;
        req = 1'h0;
        // A full or unprotected write completes at once and leaves ready up
        chk("ready", 32'(wr && (b == 4'hF || mode == rpe_pkg::RPE_PROT_NONE)), ready);
        n = 1;
        ev_s = {ev_c, ev_u, ev_f};
        while (rsp_v !== 1'h1 && fab !== 1'h1 && dab !== 1'h1 && linv !== 1'h1 && n < 9) begin
            @(posedge clk_sys_i);
            #2;
            n++;
            ev_s = ev_s | {ev_c, ev_u, ev_f};
        end
        chk("latency", lat, n);
        rd_s = rdata;
        ab_s = {linv, fab, dab};
    endtask : xfer

    always @(posedge clk_sys_i) begin
        #2;
        lin = $random(seed);
    end

    // Whole run is about 600 cycles; this limit lies at 6000 cycles
    initial begin
        #150000;
        error_cnt++;
        end_of_test();
    end

    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        repeat (5) @(posedge clk_sys_i);
        #2;
        rst_i = 1'h0;
        for (int m = 0; m < 3; m++) begin
            for (int o = 0; o < 2; o++) begin
                mode = rpe_pkg::rpe_prot_t'(m);
                odd = o[0];
                a = 10'($random(seed));
                d = $random(seed);
                xfer(1'h1, a, d, 4'hF, 1);
                xfer(1'h0, a, 32'h0, 4'hF, 3);
                chk("rdata", d, rd_s);
                chk("flags", 32'h0, ab_s);
                for (int b = 1; b < 15 && m > 0; b++) begin
                    w = $random(seed);
                    xfer(1'h1, a, w, b[3:0], 4);
                    d = merge(d, w, b[3:0]);
                    xfer(1'h0, a, 32'h0, 4'hF, 3);
                    chk("merged", d, rd_s);
                end
            end
        end
        // Written with even sense, read back with odd: every byte fails
        mode = rpe_pkg::RPE_PROT_PARITY;
        for (int k = 0; k < 5; k++) begin
            a = 10'($random(seed));
            odd = 1'h0;
            cache = 1'h0;
            fetch = 1'h0;
            xfer(1'h1, a, $random(seed), 4'hF, 1);
            odd = 1'h1;
            fetch = k[0];
            cache = k[1];
            if (k == 4) begin
                xfer(1'h1, a, 32'h0, 4'h1, 3);
            end else begin
                xfer(1'h0, a, 32'h0, 4'hF, 3);
            end
            if (cache) begin
                chk("inval", {a, 1'h1}, {linv_a, ab_s[2]});
            end else begin
                chk("abort", {fetch, !fetch}, ab_s[1:0]);
                chk("fault", {3'h4, a}, {f_st, f_addr});
            end
        end
        // Zero word stored with odd parity reads in code mode as one flip of data bit 3
        mode = rpe_pkg::RPE_PROT_PARITY;
        odd = 1'h1;
        a = 10'($random(seed));
        xfer(1'h1, a, 32'h0, 4'hF, 1);
        mode = rpe_pkg::RPE_PROT_ECC;
        xfer(1'h0, a, 32'h0, 4'hF, 4);
        chk("corr_data", 32'h8, rd_s);
        chk("corr_stat", {3'h1, a, 3'h4}, {f_st, f_addr, ev_s});
        xfer(1'h0, a, 32'h0, 4'hF, 3);
        chk("write_back", 32'h8, rd_s);
        chk("wb_events", 32'h0, {ab_s, ev_s});
        // Word 1 stored with even parity reads in code mode as a double flip
        for (int j = 0; j < 2; j++) begin
            mode = rpe_pkg::RPE_PROT_PARITY;
            odd = 1'h0;
            a = 10'($random(seed));
            xfer(1'h1, a, 32'h1, 4'hF, 1);
            mode = rpe_pkg::RPE_PROT_ECC;
            cache = 1'h1;
            dirty = j[0];
            fetch = 1'h1;
            xfer(1'h0, a, 32'h0, 4'hF, 3);
            chk("dbl_stat", {j[0] ? 3'h4 : 3'h3, a}, {f_st, f_addr});
            chk("dbl_flags", {~j[0], 2'h2, 2'h1, j[0]}, {ab_s, ev_s});
        end
        @(posedge clk_sys_i);
        #2;
        chk("lock", 32'h0, ev_l);
        inject = 1'h1;
        @(posedge clk_sys_i);
        #2;
        inject = 1'h0;
        chk("lock", {1'h1, 3'h5}, {ev_l, f_st});
        @(posedge clk_sys_i);
        #2;
        chk("lock", 32'h0, ev_l);
        end_of_test();
    end
endmodule : tb_top

bind rpe_ctrl rpe_ctrl_properties #(.LOCK_DELAY(LOCK_DELAY)) u_props (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .prot_mode_i(prot_mode_i), .is_fetch_i(is_fetch_i), .req_i(req_i), .req_we_i(req_we_i),
    .req_addr_i(req_addr_i), .req_be_i(req_be_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .fetch_abort_o(fetch_abort_o), .data_abort_o(data_abort_o), .line_inval_o(line_inval_o),
    .line_inval_addr_o(line_inval_addr_o), .ev_corr_o(ev_corr_o), .ev_uncorr_o(ev_uncorr_o),
    .ev_lock_o(ev_lock_o), .fault_addr_o(fault_addr_o), .fault_status_o(fault_status_o),
    .primary_out_i(primary_out_i), .redundant_out_i(redundant_out_i), .lock_in_i(lock_in_i),
    .redundant_in_o(redundant_in_o));
